// ==== design/lpd_mem.sv ====
// memory side power-down state keeping
// Contract
// - calibrations on a shared resistor never overlap
// - tied reference pin ignores calibration commands
// - only no-ops, data bus idle during calibration
// - clock enable high throughout calibration
// - enable low with cs high enters power-down
// - no enable drop during access bursts
// - banks idle gives idle, else active power-down
// - buffers off, inputs ignored; minimum low pulse
// - no refresh in power-down; duration limited; no limit is kept here, the user's wake timing decides
// - exit with enable and cs high
// - commands only after exit latency
// - two stable clocks before exit
// - read to power-down spacing
// - write to power-down spacing
// - auto-precharge write to power-down spacing
// - refresh/activate/precharge then hold time
// - mode write period before power-down
// - deep power-down entry code, then no-op
// - deep power-down loses array, disables all
// - deep exit needs full reinitialisation; here any one plain mode write clears NEEDS_INIT
// - frequency change rules with enable low
// - stopped clock parked low
`timescale 1ns/1ps
module lpd_mem
    import lpd_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // link
    lpd_link_if.mem LINK,
    // status
    output logic POWER_DOWN,
    output logic ACTIVE_PD,
    output logic DEEP_PD,
    output logic NEEDS_INIT,
    output logic CMD_VALID,
    output logic [2:0] CMD_OUT,
    output logic CAL_BUSY,
    output logic ILLEGAL
);
    lpd_state_t state_reg;
    logic cke_prev_reg;
    logic row_open_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic cmd_take;
    assign cmd_take = LINK.clk_en && cke_prev_reg && !LINK.cs_n;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cke_prev_reg <= 1'b0;
        end else begin
            cke_prev_reg <= LINK.clk_en;
        end
    end

    // banks tracked only as one open-row flag
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            row_open_reg <= 1'b0;
        end else if (state_reg == ST_DEEP) begin
            row_open_reg <= 1'b0;
        end else if (state_reg == ST_RUN && cmd_take) begin
            if (LINK.cmd == CMD_ACT) begin
                row_open_reg <= 1'b1;
            end else if (LINK.cmd == CMD_PRE) begin
                row_open_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_RUN;
            cnt_reg <= '0;
            POWER_DOWN <= 1'b0;
            ACTIVE_PD <= 1'b0;
            DEEP_PD <= 1'b0;
            NEEDS_INIT <= 1'b0;
            CAL_BUSY <= 1'b0;
            ILLEGAL <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    if (cke_prev_reg && !LINK.clk_en) begin
                        if (LINK.cs_n) begin
                            state_reg <= ST_PD;
                            POWER_DOWN <= 1'b1;
                            ACTIVE_PD <= row_open_reg;
                        end else if (LINK.cmd == CMD_DEEP) begin
                            state_reg <= ST_DEEP;
                            DEEP_PD <= 1'b1;
                            NEEDS_INIT <= 1'b1;
                        end
                    end else if (cmd_take && LINK.cmd == CMD_MODE && LINK.sub != MW_PLAIN) begin
                        if (LINK.ref_pin_tied) begin
                            state_reg <= ST_RUN;
                        end else begin
                            state_reg <= ST_CAL;
                            CAL_BUSY <= 1'b1;
                            unique case (LINK.sub)
                                MW_CAL_INIT: cnt_reg <= CNT_W'(CAL_INIT_CK - 1);
                                MW_CAL_LONG: cnt_reg <= CNT_W'(CAL_LONG_CK - 1);
                                default: cnt_reg <= CNT_W'(CAL_SHORT_CK - 1);
                            endcase
                        end
                    end else if (cmd_take && NEEDS_INIT && LINK.cmd == CMD_MODE) begin
                        NEEDS_INIT <= 1'b0;
                    end
                end
                ST_PD: begin
                    // inputs other than enable and cs ignored, no refresh runs
                    if (LINK.clk_en && LINK.cs_n) begin
                        state_reg <= ST_PD_EXIT;
                        cnt_reg <= CNT_W'(XP_CK - 1);
                    end
                end
                ST_PD_EXIT: begin
                    if (!LINK.cs_n && LINK.cmd != CMD_NOP) begin
                        ILLEGAL <= 1'b1;
                    end
                    if (cnt_reg == '0) begin
                        state_reg <= ST_RUN;
                        POWER_DOWN <= 1'b0;
                        ACTIVE_PD <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_DEEP: begin
                    if (LINK.clk_en) begin
                        state_reg <= ST_RUN;
                        DEEP_PD <= 1'b0;
                    end
                end
                ST_CAL: begin
                    if (!LINK.clk_en || (!LINK.cs_n && LINK.cmd != CMD_NOP)) begin
                        ILLEGAL <= 1'b1;
                    end
                    if (cnt_reg == '0) begin
                        state_reg <= ST_RUN;
                        CAL_BUSY <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    // only running state forwards commands; buffers off otherwise
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            CMD_VALID <= 1'b0;
            CMD_OUT <= CMD_NOP;
        end else begin
            CMD_VALID <= (state_reg == ST_RUN) && cmd_take && LINK.cmd != CMD_NOP;
            CMD_OUT <= LINK.cmd;
        end
    end

    assign LINK.dq_oe_mem = 1'b0;
endmodule : lpd_mem

// ==== design/lpd_pkg.sv ====
// shared constants and types for the low-power memory link
package lpd_pkg;
    localparam int CMD_W = 3;
    // command bit patterns on cs_n low (bit0, bit1, bit2)
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_DEEP = 3'h3;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_ACT = 3'h2;
    localparam logic [2:0] CMD_PRE = 3'h6;
    localparam logic [2:0] CMD_MODE = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h4;
    // op kinds asked by the controller user
    typedef enum logic [3:0] {
        OP_NONE, OP_READ, OP_WRITE, OP_WRITE_AP, OP_MRR, OP_MRW, OP_ACT, OP_PRE,
        OP_REF, OP_CAL_INIT, OP_CAL_LONG, OP_CAL_SHORT, OP_CAL_RESET
    } lpd_op_t;
    // mode write sub-codes carried on address lines
    localparam logic [1:0] MW_PLAIN = 2'h0;
    localparam logic [1:0] MW_CAL_INIT = 2'h1;
    localparam logic [1:0] MW_CAL_LONG = 2'h2;
    localparam logic [1:0] MW_CAL_SHORT = 2'h3;
    localparam int CLK_PS = 25000;
    // times in ps, except T_MRW_CK in cycles
    localparam int T_XP_PS = 7500;
    localparam int T_CKE_PS = 7500;
    localparam int T_IHCKE_PS = 250;
    localparam int T_ISCKE_PS = 250;
    localparam int T_WR_PS = 15000;
    localparam int T_DQSCK_PS = 5500;
    localparam int T_MRW_CK = 5;
    localparam int T_CAL_INIT_PS = 1000000;
    localparam int T_CAL_LONG_PS = 360000;
    localparam int T_CAL_SHORT_PS = 90000;
    // cycle counts, least times rounded up, never below one
    function automatic int cyc_up(input int ps);
        int c;
        c = (ps + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up
    localparam int XP_CK = cyc_up(T_XP_PS);
    localparam int CKE_CK = cyc_up(T_CKE_PS);
    localparam int IHCKE_CK = cyc_up(T_IHCKE_PS);
    localparam int ISCKE_CK = cyc_up(T_ISCKE_PS);
    localparam int WR_CK = cyc_up(T_WR_PS);
    localparam int DQSCK_CK = cyc_up(T_DQSCK_PS);
    localparam int CAL_INIT_CK = cyc_up(T_CAL_INIT_PS);
    localparam int CAL_LONG_CK = cyc_up(T_CAL_LONG_PS);
    localparam int CAL_SHORT_CK = cyc_up(T_CAL_SHORT_PS);
    localparam int RL_CK = 3;
    localparam int WL_CK = 1;
    localparam int BL = 4;
    localparam int RD_PD_CK = RL_CK + DQSCK_CK + BL / 2 + 1;
    localparam int WR_PD_CK = WL_CK + 1 + BL / 2 + WR_CK;
    localparam int WRA_PD_CK = WL_CK + 1 + BL / 2 + WR_CK + 1;
    localparam int STABLE_CK = 2;
    localparam int CNT_W = 16;
    typedef enum logic [2:0] {
        ST_RUN, ST_PD, ST_PD_EXIT, ST_DEEP, ST_CAL
    } lpd_state_t;
endpackage : lpd_pkg

// ==== design/lpd_link_if.sv ====
// command link between memory controller and memory
`timescale 1ns/1ps
interface lpd_link_if;
    logic clk_en;
    logic cs_n;
    logic [2:0] cmd;
    logic [1:0] sub;
    logic clk_run;
    logic dq_oe_mem;
    logic ref_pin_tied;
    modport ctrl (output clk_en, output cs_n, output cmd, output sub, output clk_run, input dq_oe_mem);
    modport mem (input clk_en, input cs_n, input cmd, input sub, input clk_run, output dq_oe_mem,
        input ref_pin_tied);
endinterface : lpd_link_if

// ==== design/lpd_ctrl.sv ====
// controller side: command spacing before power-down and exit
`timescale 1ns/1ps
module lpd_ctrl
    import lpd_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // user requests
    input wire logic OP_VALID,
    input wire lpd_op_t OP_KIND,
    input wire logic PD_REQ,
    input wire logic DEEP_REQ,
    input wire logic WAKE_REQ,
    output logic OP_READY,
    output logic IN_PD,
    // link
    lpd_link_if.ctrl LINK
);
    lpd_state_t state_reg;
    logic [CNT_W-1:0] guard_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic cke_reg, cs_n_reg, clk_run_reg;
    logic [2:0] cmd_reg;
    logic [1:0] sub_reg;
    logic [CNT_W-1:0] guard_next;
    logic [2:0] cmd_next;

    always_comb begin
        guard_next = (guard_reg != '0) ? guard_reg - 1'b1 : '0;
        cmd_next = CMD_NOP;
        unique case (OP_KIND)
            OP_READ: begin cmd_next = CMD_READ; guard_next = CNT_W'(RD_PD_CK); end
            OP_MRR: begin cmd_next = CMD_MODE; guard_next = CNT_W'(RD_PD_CK); end
            OP_WRITE: begin cmd_next = CMD_WRITE; guard_next = CNT_W'(WR_PD_CK); end
            OP_WRITE_AP: begin cmd_next = CMD_WRITE; guard_next = CNT_W'(WRA_PD_CK); end
            OP_MRW: begin cmd_next = CMD_MODE; guard_next = CNT_W'(T_MRW_CK); end
            OP_ACT: begin cmd_next = CMD_ACT; guard_next = CNT_W'(IHCKE_CK); end
            OP_PRE: begin cmd_next = CMD_PRE; guard_next = CNT_W'(IHCKE_CK); end
            OP_REF: begin cmd_next = CMD_REF; guard_next = CNT_W'(IHCKE_CK); end
            default: begin cmd_next = CMD_MODE; guard_next = '0; end
        endcase
        if (!(OP_VALID && OP_READY)) begin
            cmd_next = CMD_NOP;
            guard_next = (guard_reg != '0) ? guard_reg - 1'b1 : '0;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_RUN;
            guard_reg <= '0;
            cnt_reg <= '0;
            cke_reg <= 1'b1;
            cs_n_reg <= 1'b1;
            cmd_reg <= CMD_NOP;
            sub_reg <= MW_PLAIN;
            clk_run_reg <= 1'b1;
            OP_READY <= 1'b0;
            IN_PD <= 1'b0;
        end else begin
            cs_n_reg <= 1'b1;
            cmd_reg <= CMD_NOP;
            sub_reg <= MW_PLAIN;
            guard_reg <= guard_next;
            if (cnt_reg != '0) cnt_reg <= cnt_reg - 1'b1;
            unique case (state_reg)
                ST_RUN: begin
                    OP_READY <= 1'b1;
                    if (OP_VALID && OP_READY) begin
                        cs_n_reg <= 1'b0;
                        cmd_reg <= cmd_next;
                        unique case (OP_KIND)
                            OP_CAL_INIT: begin sub_reg <= MW_CAL_INIT; cnt_reg <= CNT_W'(CAL_INIT_CK); end
                            OP_CAL_LONG: begin sub_reg <= MW_CAL_LONG; cnt_reg <= CNT_W'(CAL_LONG_CK); end
                            OP_CAL_SHORT: begin sub_reg <= MW_CAL_SHORT; cnt_reg <= CNT_W'(CAL_SHORT_CK); end
                            default: sub_reg <= MW_PLAIN;
                        endcase
                        if (OP_KIND inside {OP_CAL_INIT, OP_CAL_LONG, OP_CAL_SHORT}) begin
                            state_reg <= ST_CAL;
                            OP_READY <= 1'b0;
                        end
                    end else if ((PD_REQ || DEEP_REQ) && guard_reg == '0 && cnt_reg == '0) begin
                        cke_reg <= 1'b0;
                        OP_READY <= 1'b0;
                        IN_PD <= 1'b1;
                        // clock keeps running for the longer of min low pulse and two cycles
                        cnt_reg <= CNT_W'((CKE_CK > STABLE_CK) ? CKE_CK : STABLE_CK);
                        if (DEEP_REQ) begin
                            cs_n_reg <= 1'b0;
                            cmd_reg <= CMD_DEEP;
                            state_reg <= ST_DEEP;
                        end else begin
                            state_reg <= ST_PD;
                        end
                    end
                end
                ST_CAL: begin
                    // only no-ops while calibrating, enable stays high
                    if (cnt_reg == '0) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_PD, ST_DEEP: begin
                    // clock stopped by user wake timing, parked low
                    clk_run_reg <= !(cnt_reg == '0 && !WAKE_REQ);
                    if (WAKE_REQ && cnt_reg == '0 && clk_run_reg) begin
                        state_reg <= ST_PD_EXIT;
                        cnt_reg <= CNT_W'(STABLE_CK - 1);
                    end
                end
                ST_PD_EXIT: begin
                    if (cnt_reg == '0 && !cke_reg) begin
                        cke_reg <= 1'b1;
                        cnt_reg <= CNT_W'((XP_CK > CKE_CK) ? XP_CK : CKE_CK);
                    end else if (cnt_reg == '0) begin
                        state_reg <= ST_RUN;
                        IN_PD <= 1'b0;
                    end
                end
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    assign LINK.clk_en = cke_reg;
    assign LINK.cs_n = cs_n_reg;
    assign LINK.cmd = cmd_reg;
    assign LINK.sub = sub_reg;
    assign LINK.clk_run = clk_run_reg;
    // refresh timing stays with the user; reinit after deep exit too
endmodule : lpd_ctrl

// ==== test/lpd_link_properties.sv ====
// link rules checked at the command pins
`timescale 1ns/1ps
module lpd_link_properties
    import lpd_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // link pins
    input wire logic clk_en,
    input wire logic cs_n,
    input wire logic [2:0] cmd,
    input wire logic [1:0] sub,
    input wire logic clk_run,
    input wire logic dq_oe_mem,
    input wire logic ref_pin_tied
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    logic [CNT_W-1:0] cal_left_reg;
    logic [CNT_W-1:0] cal_left_next;
    logic cal_cmd;
    assign cal_cmd = clk_en && !cs_n && cmd == CMD_MODE && sub != MW_PLAIN;
    // one short of the period, so a start seen a cycle late never trips
    always_comb begin
        cal_left_next = (cal_left_reg == '0) ? '0 : cal_left_reg - 1'b1;
        if (cal_cmd) begin
            case (sub)
                MW_CAL_INIT: cal_left_next = CNT_W'(CAL_INIT_CK - 1);
                MW_CAL_LONG: cal_left_next = CNT_W'(CAL_LONG_CK - 1);
                default: cal_left_next = CNT_W'(CAL_SHORT_CK - 1);
            endcase
        end
    end
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cal_left_reg <= '0;
        end else begin
            cal_left_reg <= cal_left_next;
        end
    end
    sequence read_taken;
        clk_en && !cs_n && cmd == CMD_READ;
    endsequence
    sequence write_taken;
        clk_en && !cs_n && cmd == CMD_WRITE;
    endsequence
    sequence mode_taken;
        clk_en && !cs_n && cmd == CMD_MODE;
    endsequence
    sequence deep_entry;
        $fell(clk_en) && !cs_n && cmd == CMD_DEEP;
    endsequence
    sequence nop_next;
        ##1 (cs_n || cmd == CMD_NOP);
    endsequence
    a_pd_entry_nop: assert property ($fell(clk_en) && cs_n |-> nop_next)
        else $error("no nop after power-down entry");
    a_deep_entry_nop: assert property (deep_entry |-> nop_next)
        else $error("no nop after deep power-down entry");
    a_low_pulse_min: assert property ($fell(clk_en) |=> !clk_en)
        else $error("clock enable low pulse too short");
    a_exit_cs_high: assert property ($rose(clk_en) |-> cs_n ##1 clk_en)
        else $error("power-down exit without cs high or held");
    a_stable_clock_exit: assert property ($rose(clk_en) |-> $past(clk_run, 1) && $past(clk_run, 2))
        else $error("exit without two running clocks");
    a_freq_hold: assert property ($fell(clk_en) |=> clk_run [*2])
        else $error("clock stopped too soon after enable fell");
    a_clk_stop_parked: assert property (!clk_run |-> !clk_en)
        else $error("clock stopped with enable high");
    a_cal_quiet: assert property (cal_left_reg != '0 |-> clk_en && (cs_n || cmd == CMD_NOP) && !dq_oe_mem)
        else $error("activity during calibration");
    a_read_pd_gap: assert property (read_taken |=> clk_en [*6])
        else $error("enable dropped too soon after read");
    a_write_pd_gap: assert property (write_taken |=> clk_en [*4])
        else $error("enable dropped too soon after write");
    a_mode_pd_gap: assert property (mode_taken |=> clk_en [*4])
        else $error("enable dropped inside mode write period");
    a_outputs_off: assert property (!clk_en |-> !dq_oe_mem)
        else $error("data driven in power-down");
endmodule : lpd_link_properties

// ==== test/testbench.sv ====
// bench joining controller and memory ends over the link
`timescale 1ns/1ps
module testbench;
    import lpd_pkg::*;
    // whole run needs a few thousand cycles at most
    localparam int LIMIT = 20000;
    logic clk, rst_n, op_valid, pd_req, deep_req, wake_req, ref_tied, act;
    lpd_op_t op_kind;
    logic op_ready, in_pd, power_down, active_pd, deep_pd, needs_init, cmd_valid, cal_busy, illegal;
    logic [2:0] cmd_out;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    lpd_op_t rnd_ops[7] = '{OP_READ, OP_WRITE, OP_WRITE_AP, OP_MRR, OP_ACT, OP_PRE, OP_REF};
    lpd_op_t open_ops[4] = '{OP_READ, OP_WRITE, OP_MRR, OP_ACT};
    lpd_op_t cal_ops[4] = '{OP_CAL_INIT, OP_CAL_LONG, OP_CAL_SHORT, OP_CAL_RESET};
    lpd_link_if i_lpd_link_if ();
    assign i_lpd_link_if.ref_pin_tied = ref_tied;
    lpd_ctrl i_lpd_ctrl (.CLOCK(clk), .RST_N(rst_n), .OP_VALID(op_valid), .OP_KIND(op_kind), .PD_REQ(pd_req),
        .DEEP_REQ(deep_req), .WAKE_REQ(wake_req), .OP_READY(op_ready), .IN_PD(in_pd), .LINK(i_lpd_link_if.ctrl));
    lpd_mem i_lpd_mem (.CLOCK(clk), .RST_N(rst_n), .LINK(i_lpd_link_if.mem), .POWER_DOWN(power_down),
        .ACTIVE_PD(active_pd), .DEEP_PD(deep_pd), .NEEDS_INIT(needs_init), .CMD_VALID(cmd_valid),
        .CMD_OUT(cmd_out), .CAL_BUSY(cal_busy), .ILLEGAL(illegal));
    lpd_link_properties i_lpd_link_properties (.CLOCK(clk), .RST_N(rst_n), .clk_en(i_lpd_link_if.clk_en),
        .cs_n(i_lpd_link_if.cs_n), .cmd(i_lpd_link_if.cmd), .sub(i_lpd_link_if.sub),
        .clk_run(i_lpd_link_if.clk_run), .dq_oe_mem(i_lpd_link_if.dq_oe_mem),
        .ref_pin_tied(i_lpd_link_if.ref_pin_tied));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // mode reads and writes share one command code
    function automatic logic [2:0] exp_cmd(input lpd_op_t kind);
        case (kind)
            OP_READ: return CMD_READ;
            OP_WRITE, OP_WRITE_AP: return CMD_WRITE;
            OP_ACT: return CMD_ACT;
            OP_PRE: return CMD_PRE;
            OP_REF: return CMD_REF;
            default: return CMD_MODE;
        endcase
    endfunction : exp_cmd
    task automatic do_op(input lpd_op_t kind);
        int n;
        logic [2:0] exp;
        n = 0;
        exp = exp_cmd(kind);
        op_kind = kind;
        op_valid = 1'b1;
        // ready seen settled after the edge is what the next edge samples
        while (op_ready !== 1'b1 && n < 50000) begin
            step(1);
            n++;
        end
        step(1);
        op_valid = 1'b0;
        n = 0;
        while (cmd_valid !== 1'b1 && n < 6) begin
            step(1);
            n++;
        end
        check("cmd_out", exp, cmd_out);
    endtask : do_op
    task automatic wait_pd(input logic lvl);
        int n;
        n = 0;
        while (in_pd !== lvl && n < 40) begin
            step(1);
            n++;
        end
        check("in_pd", {2'h0, lvl}, {2'h0, in_pd});
    endtask : wait_pd
    task automatic pd_cycle(input logic open_row);
        pd_req = 1'b1;
        wait_pd(1'b1);
        pd_req = 1'b0;
        op_kind = OP_READ;
        op_valid = 1'b1;
        step(2);
        check("power_down", 3'h1, {2'h0, power_down});
        check("active_pd", {2'h0, open_row}, {2'h0, active_pd});
        check("cmd_valid", 3'h0, {2'h0, cmd_valid});
        op_valid = 1'b0;
        // late wake lets the clock stop and restart before exit
        if (open_row) step(3);
        wake_req = 1'b1;
        wait_pd(1'b0);
        wake_req = 1'b0;
        check("power_down", 3'h0, {2'h0, power_down});
        check("illegal", 3'h0, {2'h0, illegal});
    endtask : pd_cycle
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            $display("ERROR cycles expected %0d seen %0d", LIMIT - 1, cycles);
            give_verdict();
        end
    end
    initial begin
        void'($urandom(89));
        rst_n = 1'b0;
        op_valid = 1'b0;
        op_kind = OP_NONE;
        pd_req = 1'b0;
        deep_req = 1'b0;
        wake_req = 1'b0;
        ref_tied = 1'b0;
        act = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        step(2);
        check("op_ready", 3'h1, {2'h0, op_ready});
        check("status", 3'h0, {power_down, deep_pd, needs_init});
        for (int i = 0; i < 20; i++) begin
            repeat ($urandom_range(3)) do_op(rnd_ops[$urandom_range(6)]);
            act = 1'($urandom_range(1));
            do_op(act ? OP_ACT : OP_PRE);
            if (act) begin
                do_op(open_ops[$urandom_range(3)]);
            end else begin
                do_op($urandom_range(1) ? OP_MRW : OP_REF);
            end
            pd_cycle(act);
        end
        foreach (cal_ops[i]) begin
            do_op(cal_ops[i]);
            step(1);
            if (cal_ops[i] != OP_CAL_RESET) check("cal_busy", 3'h1, {2'h0, cal_busy});
        end
        ref_tied = 1'b1;
        do_op(OP_CAL_SHORT);
        step(1);
        check("cal_busy", 3'h0, {2'h0, cal_busy});
        ref_tied = 1'b0;
        do_op(OP_PRE);
        deep_req = 1'b1;
        wait_pd(1'b1);
        deep_req = 1'b0;
        step(2);
        check("deep_pd", 3'h1, {2'h0, deep_pd});
        check("needs_init", 3'h1, {2'h0, needs_init});
        wake_req = 1'b1;
        wait_pd(1'b0);
        wake_req = 1'b0;
        check("deep_pd", 3'h0, {2'h0, deep_pd});
        check("needs_init", 3'h1, {2'h0, needs_init});
        do_op(OP_MRW);
        step(2);
        check("needs_init", 3'h0, {2'h0, needs_init});
        check("illegal", 3'h0, {2'h0, illegal});
        give_verdict();
    end
endmodule : testbench
